// *** core/osc_link_pkg.sv ***
package osc_link_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_MHZ = 100;
  localparam int NV_WRITE_US = 10000;
  localparam int NV_WRITE_CYCLES = NV_WRITE_US * CLK_MHZ;

  // ==========================================================
  // Command codes
  localparam logic [7:0] CMD_DAC = 8'h08;
  localparam logic [7:0] CMD_OFFSET = 8'h0e;
  localparam logic [7:0] CMD_DIV = 8'h01;
  localparam logic [7:0] CMD_MUX = 8'h02;
  localparam logic [7:0] CMD_ADDR = 8'h0d;
  localparam logic [7:0] CMD_RANGE = 8'h37;
  localparam logic [7:0] CMD_COMMIT = 8'h3f;

  // ==========================================================
  // Setting reset values and fields
  localparam logic [9:0] DAC_RST = 10'h000;
  localparam logic [4:0] OFFSET_RST = 5'h00;
  localparam logic [9:0] DIV_RST = 10'h000;
  localparam logic [9:0] MUX_RST = 10'h000;
  localparam logic [4:0] ADDR_RST = 5'h00;
  localparam int COMMIT_MODE_BIT = 3;

  // ==========================================================
  // Register bus map
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_DACOFF = 8'h08;
  localparam logic [7:0] A_DIVMUX = 8'h0c;
  localparam logic [7:0] A_ADDR = 8'h10;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Link states, Gray along the usual path
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX = 3'b001,
    ST_ACK = 3'b011,
    ST_TX = 3'b010,
    ST_RACK = 3'b110
  } link_st_t;
endpackage : osc_link_pkg

// *** core/osc_link_slave.sv ***
// Chosen here: the register offsets and register access over AXI4-Lite.
module osc_link_slave #(
  // Arbitrary neutral device type code
  parameter logic [3:0] TYPE_CODE = 4'h5,
  parameter logic [15:0] RANGE_VALUE = 16'h0000,
  parameter int NV_CYCLES = osc_link_pkg::NV_WRITE_CYCLES
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_drv_out,
  output logic sda_oe_out,
  output logic [9:0] dac_out,
  output logic [4:0] offset_out,
  output logic [9:0] div_out,
  output logic [9:0] output_select_word_out,
  output logic nv_commit_mode_out,
  output logic nv_write_out,
  output logic nv_busy_out,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  output logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  input wire logic [7:0] s_axi_araddr_in,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out
);
  localparam int CW = $clog2(NV_CYCLES + 1);

  typedef struct packed {
    logic [1:0] sy1;
    logic [1:0] sy2;
    logic [1:0] sy3;
    logic [1:0] flt;
    logic [1:0] prv;
    osc_link_pkg::link_st_t st;
    logic [3:0] bits;
    logic [7:0] shr;
    logic [1:0] nbyte;
    logic [1:0] di;
    logic rw;
    logic oe;
    logic ackd;
    logic [7:0] cmd;
    logic [9:0] dac;
    logic [4:0] off;
    logic [9:0] div;
    logic [9:0] output_select_word;
    logic [4:0] adr;
    logic dirty;
    logic adr_wr;
    logic commit_req;
    logic [CW-1:0] nv_cnt;
    logic nv_busy;
    logic nv_pulse;
    logic ctrl_en;
    logic aw_ok;
    logic w_ok;
    logic [7:0] aw_a;
    logic [31:0] wd;
    logic ws0;
    logic awrdy;
    logic wrdy;
    logic bvalid;
    logic [1:0] bresp;
    logic arrdy;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } state_t;

  state_t q;
  state_t d;

  // ==========================================================
  // Helpers
  function automatic logic [9:0] put10(input logic [9:0] old,
    input logic [7:0] b, input logic [1:0] idx);
    logic [9:0] r;
    r = old;
    if (idx == 2'd0)
    begin
      r[9:2] = b;
    end
    else if (idx == 2'd1)
    begin
      r[1:0] = b[7:6];
    end
    return r;
  endfunction : put10

  function automatic logic [7:0] get10(input logic [9:0] v,
    input logic [1:0] idx);
    return (idx == 2'd0) ? v[9:2] : {v[1:0], 6'h00};
  endfunction : get10

  function automatic logic [7:0] rd_byte(input state_t s);
    logic [7:0] r;
    r = 8'hff;
    unique case (s.cmd)
      osc_link_pkg::CMD_DAC: r = get10(s.dac, s.di);
      osc_link_pkg::CMD_DIV: r = get10(s.div, s.di);
      osc_link_pkg::CMD_MUX: r = get10(s.output_select_word, s.di);
      osc_link_pkg::CMD_OFFSET: r = {3'h7, s.off};
      osc_link_pkg::CMD_ADDR: r = {3'h0, s.adr};
      osc_link_pkg::CMD_RANGE:
        r = (s.di == 2'd0) ? RANGE_VALUE[15:8] : RANGE_VALUE[7:0];
      default: r = 8'hff;
    endcase
    return r;
  endfunction : rd_byte

  function automatic logic [1:0] sat2(input logic [1:0] v);
    return (v == 2'd3) ? v : v + 2'd1;
  endfunction : sat2

  // ==========================================================
  // Next state
  logic scl;
  logic sda;
  logic scl_r;
  logic scl_f;
  logic start;
  logic stop;
  logic cmode;
  logic [7:0] b;
  logic [7:0] tb;

  always_comb
  begin
    d = q;
    b = q.shr;
    tb = 8'h00;
    d.nv_pulse = 1'b0;
    cmode = q.adr[osc_link_pkg::COMMIT_MODE_BIT];
    d.sy1 = {scl_in, sda_in};
    d.sy2 = q.sy1;
    d.sy3 = q.sy2;
    if (q.sy2 == q.sy3)
    begin
      d.flt = q.sy2;
    end
    d.prv = q.flt;
    scl = q.flt[1];
    sda = q.flt[0];
    scl_r = scl & ~q.prv[1];
    scl_f = ~scl & q.prv[1];
    start = scl & q.prv[1] & q.prv[0] & ~sda;
    stop = scl & q.prv[1] & ~q.prv[0] & sda;

    if (q.nv_busy)
    begin
      if (q.nv_cnt == CW'(NV_CYCLES - 1))
      begin
        d.nv_busy = 1'b0;
      end
      else
      begin
        d.nv_cnt = q.nv_cnt + 1'b1;
      end
    end
    // Write command ends at STOP or START
    if ((start | stop) &
      (q.adr_wr | (q.dirty & ~cmode) | q.commit_req) & ~q.nv_busy)
    begin
      // One pulse latches all five settings
      d.nv_busy = 1'b1;
      d.nv_cnt = '0;
      d.nv_pulse = 1'b1;
    end
    if (start | stop)
    begin
      d.dirty = 1'b0;
      d.adr_wr = 1'b0;
      d.commit_req = 1'b0;
    end

    if (start)
    begin
      d.st = osc_link_pkg::ST_RX;
      d.bits = 4'd0;
      d.nbyte = 2'd0;
      d.oe = 1'b0;
    end
    else if (stop)
    begin
      d.st = osc_link_pkg::ST_IDLE;
      d.oe = 1'b0;
    end
    else
    begin
      unique case (q.st)
        osc_link_pkg::ST_IDLE:
        begin
          d.oe = 1'b0;
        end
        osc_link_pkg::ST_RX:
        begin
          if (scl_r && q.bits != 4'd8)
          begin
            d.shr = {q.shr[6:0], sda};
            d.bits = q.bits + 4'd1;
          end
          else if (scl_f && q.bits == 4'd8)
          begin
            d.st = osc_link_pkg::ST_ACK;
            d.bits = 4'd0;
            d.ackd = 1'b1;
            d.oe = 1'b1;
            if (q.nbyte == 2'd0)
            begin
              if (b[7:4] != TYPE_CODE || b[3:1] != q.adr[2:0]
                || q.nv_busy || !q.ctrl_en)
              begin
                d.st = osc_link_pkg::ST_IDLE;
                d.oe = 1'b0;
                d.ackd = 1'b0;
              end
              else
              begin
                d.rw = b[0];
                d.nbyte = 2'd1;
                d.di = 2'd0;
              end
            end
            else if (q.nbyte == 2'd1)
            begin
              d.cmd = b;
              d.nbyte = 2'd2;
              if (b == osc_link_pkg::CMD_COMMIT && cmode)
              begin
                d.commit_req = 1'b1;
              end
            end
            else
            begin
              d.di = sat2(q.di);
              unique case (q.cmd)
                osc_link_pkg::CMD_DAC:
                begin
                  d.dac = put10(q.dac, b, q.di);
                  d.dirty = 1'b1;
                end
                osc_link_pkg::CMD_DIV:
                begin
                  d.div = put10(q.div, b, q.di);
                  d.dirty = 1'b1;
                end
                osc_link_pkg::CMD_MUX:
                begin
                  d.output_select_word = put10(q.output_select_word, b, q.di);
                  d.dirty = 1'b1;
                end
                osc_link_pkg::CMD_OFFSET:
                begin
                  if (q.di == 2'd0)
                  begin
                    d.off = b[4:0];
                    d.dirty = 1'b1;
                  end
                end
                osc_link_pkg::CMD_ADDR:
                begin
                  if (q.di == 2'd0)
                  begin
                    d.adr = b[4:0];
                    d.adr_wr = 1'b1;
                  end
                end
                default: d.di = sat2(q.di);
              endcase
            end
          end
        end
        osc_link_pkg::ST_ACK:
        begin
          if (scl_f)
          begin
            d.oe = 1'b0;
            d.bits = 4'd0;
            if (q.rw)
            begin
              tb = rd_byte(q);
              d.shr = tb;
              d.oe = ~tb[7];
              d.di = sat2(q.di);
              d.st = osc_link_pkg::ST_TX;
            end
            else
            begin
              d.st = osc_link_pkg::ST_RX;
            end
          end
        end
        osc_link_pkg::ST_TX:
        begin
          if (scl_r)
          begin
            d.bits = q.bits + 4'd1;
          end
          // Change data only after clock falls
          else if (scl_f)
          begin
            if (q.bits == 4'd8)
            begin
              d.st = osc_link_pkg::ST_RACK;
              d.oe = 1'b0;
            end
            else
            begin
              d.shr = {q.shr[6:0], 1'b0};
              d.oe = ~q.shr[6];
            end
          end
        end
        osc_link_pkg::ST_RACK:
        begin
          if (scl_r)
          begin
            d.ackd = ~sda;
          end
          else if (scl_f)
          begin
            d.bits = 4'd0;
            // After NACK the line stays released
            if (!q.ackd)
            begin
              d.st = osc_link_pkg::ST_IDLE;
            end
            else
            begin
              tb = rd_byte(q);
              d.shr = tb;
              d.oe = ~tb[7];
              d.di = sat2(q.di);
              d.st = osc_link_pkg::ST_TX;
            end
          end
        end
        default:
        begin
          d.st = osc_link_pkg::ST_IDLE;
          d.oe = 1'b0;
        end
      endcase
    end

    // ==========================================================
    // Register bus slave
    if (s_axi_awvalid_in && q.awrdy)
    begin
      d.aw_ok = 1'b1;
      d.aw_a = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && q.wrdy)
    begin
      d.w_ok = 1'b1;
      d.wd = s_axi_wdata_in;
      d.ws0 = s_axi_wstrb_in[0];
    end
    if (q.bvalid && s_axi_bready_in)
    begin
      d.bvalid = 1'b0;
    end
    // Read-only settings: link is the only writer, no races
    if (d.aw_ok && d.w_ok && !d.bvalid)
    begin
      d.aw_ok = 1'b0;
      d.w_ok = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = osc_link_pkg::RESP_OKAY;
      if (d.aw_a == osc_link_pkg::A_CTRL)
      begin
        if (d.ws0)
        begin
          d.ctrl_en = d.wd[0];
        end
      end
      else if (d.aw_a != osc_link_pkg::A_STAT
        && d.aw_a != osc_link_pkg::A_DACOFF
        && d.aw_a != osc_link_pkg::A_DIVMUX
        && d.aw_a != osc_link_pkg::A_ADDR)
      begin
        d.bresp = osc_link_pkg::RESP_SLVERR;
      end
    end
    if (q.rvalid && s_axi_rready_in)
    begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid_in && q.arrdy)
    begin
      d.rvalid = 1'b1;
      d.rresp = osc_link_pkg::RESP_OKAY;
      unique case (s_axi_araddr_in)
        osc_link_pkg::A_CTRL: d.rdata = {31'h0, q.ctrl_en};
        osc_link_pkg::A_STAT:
          d.rdata = {30'h0, q.st != osc_link_pkg::ST_IDLE, q.nv_busy};
        osc_link_pkg::A_DACOFF: d.rdata = {17'h0, q.off, q.dac};
        osc_link_pkg::A_DIVMUX: d.rdata = {12'h0, q.output_select_word, q.div};
        osc_link_pkg::A_ADDR: d.rdata = {27'h0, q.adr};
        default:
        begin
          d.rdata = 32'h0;
          d.rresp = osc_link_pkg::RESP_SLVERR;
        end
      endcase
    end
    d.awrdy = ~d.aw_ok & ~d.bvalid;
    d.wrdy = ~d.w_ok & ~d.bvalid;
    d.arrdy = ~d.rvalid;
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      q <= '0;
      // Lines idle high so reset release sees no START
      q.sy1 <= 2'b11;
      q.sy2 <= 2'b11;
      q.sy3 <= 2'b11;
      q.flt <= 2'b11;
      q.prv <= 2'b11;
      q.st <= osc_link_pkg::ST_IDLE;
      q.dac <= osc_link_pkg::DAC_RST;
      q.off <= osc_link_pkg::OFFSET_RST;
      q.div <= osc_link_pkg::DIV_RST;
      q.output_select_word <= osc_link_pkg::MUX_RST;
      q.adr <= osc_link_pkg::ADDR_RST;
      q.ctrl_en <= osc_link_pkg::CTRL_EN_RST;
    end
    else
    begin
      q <= d;
    end
  end

  // ==========================================================
  // Outputs
  // Open-drain data only, clock never driven
  assign sda_drv_out = 1'b0;
  assign sda_oe_out = q.oe;
  assign dac_out = q.dac;
  assign offset_out = q.off;
  assign div_out = q.div;
  assign output_select_word_out = q.output_select_word;
  assign nv_commit_mode_out = q.adr[osc_link_pkg::COMMIT_MODE_BIT];
  assign nv_write_out = q.nv_pulse;
  assign nv_busy_out = q.nv_busy;
  assign s_axi_awready_out = q.awrdy;
  assign s_axi_wready_out = q.wrdy;
  assign s_axi_bvalid_out = q.bvalid;
  assign s_axi_bresp_out = q.bresp;
  assign s_axi_arready_out = q.arrdy;
  assign s_axi_rvalid_out = q.rvalid;
  assign s_axi_rdata_out = q.rdata;
  assign s_axi_rresp_out = q.rresp;
endmodule : osc_link_slave

// *** tb/osc_link_monitor.sv ***
module osc_link_monitor #(
  parameter int NV_CYCLES = 200
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic scl_in,
  input wire logic sda_drv_out,
  input wire logic sda_oe_out,
  input wire logic nv_write_out,
  input wire logic nv_busy_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in
);
  timeunit 1ns;
  timeprecision 100ps;
  int busy_cnt_q;
  // ======
  // Busy cycles, so the store time is exact
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      busy_cnt_q <= 0;
    else
      busy_cnt_q <= nv_busy_out ? busy_cnt_q + 1 : 0;
  end
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);
  property p_drv_low;
    sda_drv_out == 1'b0;
  endproperty
  a_drv_low: assert property (p_drv_low)
    else $error("drive value not low");
  property p_oe_scl_low;
    $changed(sda_oe_out) |-> !scl_in;
  endproperty
  a_oe_scl_low: assert property (p_oe_scl_low)
    else $error("data drive moved with clock high");
  property p_busy_follows;
    nv_write_out |=> nv_busy_out;
  endproperty
  a_busy_follows: assert property (p_busy_follows)
    else $error("no busy after store");
  property p_pulse_one;
    nv_write_out |=> !nv_write_out;
  endproperty
  a_pulse_one: assert property (p_pulse_one)
    else $error("store pulse too long");
  property p_busy_len;
    $fell(nv_busy_out) |-> busy_cnt_q == NV_CYCLES;
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("busy length wrong");
  property p_busy_quiet;
    nv_busy_out |-> !sda_oe_out ##1 !nv_write_out;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet)
    else $error("activity while busy");
  property p_write_done;
    s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out;
  endproperty
  a_write_done: assert property (p_write_done)
    else $error("write response repeated");
  property p_read_done;
    s_axi_rvalid_out && s_axi_rready_in |=> !s_axi_rvalid_out;
  endproperty
  a_read_done: assert property (p_read_done)
    else $error("read response repeated");
  property p_read_answer;
    s_axi_arvalid_in && s_axi_arready_out |=>
      s_axi_rvalid_out && !s_axi_arready_out;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read answer late");
endmodule : osc_link_monitor

bind osc_link_slave osc_link_monitor #(.NV_CYCLES(NV_CYCLES))
  osc_link_monitor_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
  .scl_in(scl_in), .sda_drv_out(sda_drv_out), .sda_oe_out(sda_oe_out),
  .nv_write_out(nv_write_out), .nv_busy_out(nv_busy_out),
  .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
  .s_axi_arvalid_in(s_axi_arvalid_in),
  .s_axi_arready_out(s_axi_arready_out),
  .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in));

// *** tb/twm_bus_master.sv ***
module twm_bus_master (
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_pull_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // Fifth of a bit time, raised for slow-rate frames
  int unsigned qtr_ns = 25;
  // ======
  // idle bus between frames
  initial
  begin
    scl_out = 1'b1;
    sda_pull_out = 1'b0;
  end
  task automatic start();
    #(qtr_ns);
    sda_pull_out <= 1'b0;
    #(2 * qtr_ns);
    scl_out <= 1'b1;
    #(2 * qtr_ns);
    sda_pull_out <= 1'b1;
    #(2 * qtr_ns);
    scl_out <= 1'b0;
  endtask : start
  // stop, data rising with clock high
  task automatic stop();
    #(qtr_ns);
    sda_pull_out <= 1'b1;
    #(2 * qtr_ns);
    scl_out <= 1'b1;
    #(2 * qtr_ns);
    sda_pull_out <= 1'b0;
    #(10 * qtr_ns);
  endtask : stop
  // change while low, hold through high
  task automatic clk_bit(input logic b, output logic s);
    #(qtr_ns);
    sda_pull_out <= !b;
    #(2 * qtr_ns);
    scl_out <= 1'b1;
    #(qtr_ns);
    s = sda_in;
    #(qtr_ns);
    scl_out <= 1'b0;
  endtask : clk_bit
  task automatic xfer(input logic [7:0] tx, input logic mack,
                      output logic [7:0] rx, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      clk_bit(tx[i], s);
      rx[i] = s;
    end
    clk_bit(!mack, s);
    ack = !s;
  endtask : xfer
endmodule : twm_bus_master

// *** tb/tb_osc_link_slave.sv ***
module tb_osc_link_slave;
  timeunit 1ns;
  timeprecision 100ps;
  // Arbitrary type code
  localparam logic [3:0] TY = 4'h5;
  localparam logic [15:0] RG = 16'h9a40;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic scl, m_pull, sda_w, drv, oe, mode, nv_wr, nv_busy;
  logic [9:0] dac, div, output_select_word;
  logic [4:0] off;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int error_cnt = 0;
  int n_tests = 0;
  int nv_cnt = 0;
  // ======
  // Clock, pulled-up data wire, store counter
  always #5 clk_in = ~clk_in;
  assign sda_w = (oe ? drv : 1'b1) & ~m_pull;
  always @(posedge clk_in)
    if (nv_wr === 1'b1)
      nv_cnt <= nv_cnt + 1;
  osc_link_slave #(.TYPE_CODE(TY), .RANGE_VALUE(RG), .NV_CYCLES(200))
    osc_link_slave_i (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .scl_in(scl),
    .sda_in(sda_w), .sda_drv_out(drv), .sda_oe_out(oe), .dac_out(dac),
    .offset_out(off), .div_out(div), .output_select_word_out(output_select_word),
    .nv_commit_mode_out(mode), .nv_write_out(nv_wr), .nv_busy_out(nv_busy),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_awaddr_in(awaddr), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(4'hf), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_bresp_out(bresp),
    .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_araddr_in(araddr), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp));
  twm_bus_master twm_bus_master_i (.sda_in(sda_w), .scl_out(scl),
    .sda_pull_out(m_pull));
  // ======
  // Tasks
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge clk_in);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk_in);
      if (awready)
        aw = 1'b0;
      if (wready)
        w = 1'b0;
      awvalid <= aw;
      wvalid <= w;
    end while (aw || w || !bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    logic ar;
    ar = 1'b1;
    @(posedge clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk_in);
      if (arready)
        ar = 1'b0;
      arvalid <= ar;
    end while (ar || !rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axr
  task automatic snd(input logic [7:0] b, input logic ea);
    logic [7:0] x;
    logic a;
    twm_bus_master_i.xfer(b, 1'b0, x, a);
    chk("link ack", ea, a);
  endtask : snd
  task automatic rcv(input logic mack, input logic [7:0] e);
    logic [7:0] x;
    logic a;
    twm_bus_master_i.xfer(8'hff, mack, x, a);
    chk("link byte", e, x);
  endtask : rcv
  task automatic ctl(input logic [2:0] s, input logic rw, input logic ea);
    twm_bus_master_i.start();
    snd({TY, s, rw}, ea);
  endtask : ctl
  task automatic stp();
    twm_bus_master_i.stop();
  endtask : stp
  task automatic wr_cmd(input logic [2:0] s, input logic [7:0] c,
                        input logic [15:0] d, input int n);
    ctl(s, 1'b0, 1'b1);
    snd(c, 1'b1);
    for (int i = 0; i < n; i++)
      snd(d[15 - 8 * i -: 8], 1'b1);
    stp();
  endtask : wr_cmd
  task automatic settle();
    while (nv_busy !== 1'b0)
      @(posedge clk_in);
  endtask : settle
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up
  // ======
  // Watchdog, far beyond the expected run
  initial
  begin
    #500us;
    error_cnt++;
    wrap_up();
  end
  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    int n;
    repeat (10) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    for (int i = 0; i < 5; i++)
    begin
      axr(8'(4 * i), d, r);
      chk("reg reset", (i == 0) ? 32'h1 : 32'h0, d);
    end
    axw(8'h04, 32'hffffffff, r);
    chk("ro resp", 2'h0, r);
    axr(8'h04, d, r);
    chk("stat", 32'h0, d);
    axr(8'h14, d, r);
    chk("unmapped resp", 2'h2, r);
    chk("unmapped data", 32'h0, d);
    $display("test registers done");
    n = nv_cnt;
    wr_cmd(3'h0, 8'h08, 16'ha540, 2);
    chk("dac", 10'h295, dac);
    chk("stores", n + 1, nv_cnt);
    ctl(3'h0, 1'b0, 1'b0);
    stp();
    settle();
    $display("test write and busy done");
    ctl(3'h0, 1'b0, 1'b1);
    snd(8'h08, 1'b1);
    ctl(3'h0, 1'b1, 1'b1);
    rcv(1'b1, 8'ha5);
    rcv(1'b0, 8'h40);
    #200;
    chk("release", 1'b0, oe);
    stp();
    chk("stores", n + 1, nv_cnt);
    $display("test read done");
    for (int i = 0; i < 2; i++)
    begin
      wr_cmd(3'h0, i ? 8'h02 : 8'h01, i ? 16'hff80 : 16'h3340, 2);
      settle();
    end
    chk("div", 10'h0cd, div);
    chk("mux", 10'h3fe, output_select_word);
    axr(8'h0c, d, r);
    chk("div mux reg", {12'h0, 10'h3fe, 10'h0cd}, d);
    $display("test divider and select done");
    ctl(3'h1, 1'b0, 1'b0);
    snd(8'h08, 1'b0);
    stp();
    twm_bus_master_i.start();
    snd({TY ^ 4'h1, 4'h0}, 1'b0);
    stp();
    $display("test mismatch done");
    n = nv_cnt;
    wr_cmd(3'h0, 8'h0d, 16'h0900, 1);
    chk("mode", 1'b1, mode);
    chk("stores", n + 1, nv_cnt);
    settle();
    ctl(3'h0, 1'b0, 1'b0);
    stp();
    wr_cmd(3'h1, 8'h08, 16'h1240, 2);
    chk("dac", 10'h049, dac);
    chk("stores", n + 1, nv_cnt);
    wr_cmd(3'h1, 8'h3f, 16'h0000, 0);
    chk("stores", n + 2, nv_cnt);
    settle();
    wr_cmd(3'h1, 8'h0d, 16'h0800, 1);
    chk("stores", n + 3, nv_cnt);
    settle();
    axr(8'h10, d, r);
    chk("addr reg", 32'h8, d);
    $display("test address and mode done");
    wr_cmd(3'h0, 8'h0e, 16'h3500, 1);
    chk("offset", 5'h15, off);
    twm_bus_master_i.qtr_ns = 500;
    ctl(3'h0, 1'b0, 1'b1);
    snd(8'h0e, 1'b1);
    ctl(3'h0, 1'b1, 1'b1);
    rcv(1'b0, 8'hf5);
    stp();
    twm_bus_master_i.qtr_ns = 25;
    ctl(3'h0, 1'b0, 1'b1);
    snd(8'h37, 1'b1);
    ctl(3'h0, 1'b1, 1'b1);
    rcv(1'b1, RG[15:8]);
    rcv(1'b0, RG[7:0]);
    stp();
    chk("stores", n + 3, nv_cnt);
    $display("test offset range and rate done");
    axw(8'h00, 32'h0, r);
    ctl(3'h0, 1'b0, 1'b0);
    stp();
    axw(8'h00, 32'h1, r);
    ctl(3'h0, 1'b0, 1'b1);
    stp();
    $display("test enable done");
    wrap_up();
  end
endmodule : tb_osc_link_slave
